// *** pkg/lqs_pkg.sv ***
// Shared constants and types for the linear encoder output block.
// Assumes a 100 MHz ref_clk and a 32-bit AXI4-Lite register bus.
package lqs_pkg;

  // Register byte offsets, one aligned word each
  localparam logic [7:0] CTRL_OFS     = 8'h00; // Output option enables
  localparam logic [7:0] POS_OFS      = 8'h04; // Live position, read only
  localparam logic [7:0] FLAG_OFS     = 8'h08; // Live flags, read only
  localparam logic [7:0] IRQ_ST_OFS   = 8'h0c; // Sticky events, write 1 clears
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10; // Interrupt enables
  localparam logic [7:0] PRESET_OFS   = 8'h14; // Write loads position

  // Field positions and widths
  localparam int POS_W     = 22; // Binary position bits in a frame
  localparam int FRAME_W   = 25; // Position plus three status bits
  localparam int IRQ_W     = 3;  // Number of event bits
  localparam int IRQ_FRAME = 0;  // Serial frame finished
  localparam int IRQ_REF   = 1;  // Reference mark entered
  localparam int IRQ_ERR   = 2;  // Error flag rose
  localparam int FLAG_ERR  = 0;
  localparam int FLAG_WARN = 1;
  localparam int FLAG_REF  = 2;
  localparam int FLAG_BUSY = 3;

  // Reset values
  localparam logic [2:0]       CTRL_RST = 3'h7; // All outputs on
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0; // Interrupts off

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Travel per position step and per quadrature edge, in micrometres
  localparam int STEP_UM = 10;

  // Serial idle timeout after the last clock edge
  localparam int CLK_MHZ          = 100;
  localparam int SSI_TIMEOUT_NS   = 20000;
  localparam int SSI_TIMEOUT_CYC  = (SSI_TIMEOUT_NS * CLK_MHZ + 999) / 1000;
  localparam int SSI_TCNT_W       = 12;

  // Serial frame, most significant field shifted first
  typedef struct packed {
    logic [POS_W-1:0] pos;    // Binary position
    logic             parity; // Even parity over pos
    logic             err;    // Error flag
    logic             warn;   // Warning flag
  } lqs_frame_t;

  // Output option enables, bit 2 downward
  typedef struct packed {
    logic serial_absolute_option;
    logic analog_sine_option;
    logic square_wave_option;
  } lqs_ctrl_t;

  // Serial transmitter states
  typedef enum logic [1:0] {
    SSI_IDLE  = 2'h0, // Data high, waiting for first falling edge
    SSI_SHIFT = 2'h1, // Bits leave on rising edges
    SSI_HOLD  = 2'h2  // Data low until the clock stays quiet
  } lqs_ssi_st_t;

endpackage

// *** rtl/lqs_ssi_tx.sv ***
// Serial absolute position transmitter.
// Expects one-cycle edge strobes of an already synchronised serial clock.
`timescale 1ns/1ps
module lqs_ssi_tx (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic              enable,
  input  wire logic              sclk_rise,
  input  wire logic              sclk_fall,
  input  wire lqs_pkg::lqs_frame_t frame,
  output logic                   data_out,
  output logic                   busy,
  output logic                   frame_done
);

  lqs_pkg::lqs_ssi_st_t              st_q;    // Transmitter state
  logic [lqs_pkg::FRAME_W-1:0]       shreg_q; // Frame being shifted
  logic [4:0]                        bit_q;   // Bits already sent
  logic [lqs_pkg::SSI_TCNT_W-1:0]    tcnt_q;  // Cycles since last edge
  logic                              data_q;  // Line level
  logic                              done_q;  // End of frame strobe

  wire any_edge = sclk_rise | sclk_fall;
  wire last_bit = (bit_q == 5'(lqs_pkg::FRAME_W));
  wire timed_out = (tcnt_q == lqs_pkg::SSI_TCNT_W'(
                    lqs_pkg::SSI_TIMEOUT_CYC - 1));

  // One process: state, shift register and timeout move together
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q    <= lqs_pkg::SSI_IDLE;
      shreg_q <= '0;
      bit_q   <= 5'h0;
      tcnt_q  <= '0;
      data_q  <= 1'b1;
      done_q  <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      tcnt_q <= (any_edge || st_q == lqs_pkg::SSI_IDLE) ? '0 : tcnt_q + 1'b1;
      unique case (st_q)
        lqs_pkg::SSI_IDLE: begin
          data_q <= 1'b1;
          // Position is frozen at the first falling edge
          if (enable && sclk_fall) begin
            shreg_q <= frame;
            bit_q   <= 5'h0;
            st_q    <= lqs_pkg::SSI_SHIFT;
          end
        end
        lqs_pkg::SSI_SHIFT: begin
          if (!enable || timed_out) begin
            // Master gave up mid-frame, recover through hold
            data_q <= 1'b0;
            st_q   <= lqs_pkg::SSI_HOLD;
          end else if (sclk_rise && last_bit) begin
            data_q <= 1'b0;
            done_q <= 1'b1;
            st_q   <= lqs_pkg::SSI_HOLD;
          end else if (sclk_rise) begin
            // Most significant bit leaves first
            data_q  <= shreg_q[lqs_pkg::FRAME_W-1];
            shreg_q <= {shreg_q[lqs_pkg::FRAME_W-2:0], 1'b0};
            bit_q   <= bit_q + 5'h1;
          end
        end
        lqs_pkg::SSI_HOLD: begin
          // Low until the clock has rested for the timeout
          if (timed_out || !enable) begin
            data_q <= 1'b1;
            st_q   <= lqs_pkg::SSI_IDLE;
          end
        end
        default: st_q <= lqs_pkg::SSI_IDLE;
      endcase
    end
  end

  assign data_out   = data_q;
  assign busy       = (st_q != lqs_pkg::SSI_IDLE);
  assign frame_done = done_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_ssi_latch_frame: assert property (
    clk_en && st_q == lqs_pkg::SSI_IDLE && enable && sclk_fall
    |=> shreg_q == $past(frame) && st_q == lqs_pkg::SSI_SHIFT)
    else $error("frame not latched at first falling edge");
  a_ssi_msb_out: assert property (
    clk_en && st_q == lqs_pkg::SSI_SHIFT && enable && sclk_rise
    && !last_bit && !timed_out
    |=> data_q == $past(shreg_q[lqs_pkg::FRAME_W-1]))
    else $error("serial bit not taken from frame msb");
  a_ssi_back_idle: assert property (
    clk_en && st_q == lqs_pkg::SSI_HOLD && timed_out
    |=> data_q && st_q == lqs_pkg::SSI_IDLE)
    else $error("no return to idle after timeout");
  a_ssi_off_high: assert property (
    !enable && st_q == lqs_pkg::SSI_IDLE |=> data_q)
    else $error("serial line not high while disabled");
  c_ssi_frame: cover property (done_q);
endmodule

// *** rtl/lqs_top.sv ***
// Output logic of a magnetic linear encoder: quadrature, index, serial.
// Assumes step strobes and status flags come from sensor logic on
// ref_clk; the index pin and the serial clock are asynchronous.
//
// Functional notes
// - analog channels A and B ninety degrees apart
// - positive motion: B lags A; reverse otherwise
// - index low, high only over reference mark
// - square-wave A and B also in quadrature
// - each edge is ten micrometres, four per period
// - absolute position sent, clocked by evaluation unit
// - analog channels stay active during serial transfers
// - position sent as 22-bit plain binary
// - even parity, error, warning: 25 bits total
// - one position step equals ten micrometres
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module lqs_top (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Sensor front end, same clock
  input  wire logic        step_pulse,
  input  wire logic        step_up,
  input  wire logic        err_in,
  input  wire logic        warn_in,
  // Asynchronous pins
  input  wire logic        ref_mark_pin,
  input  wire logic        ssi_clk_pin,
  // Outputs
  output logic             quad_a,
  output logic             quad_b,
  output logic             zero_index_pulse,
  output logic [1:0]       ana_phase,
  output logic             ana_index,
  output logic             ssi_data,
  output logic             irq
);

  // Protection bits carry no meaning for this slave
  wire unused_prot = ^{s_axi_awprot, s_axi_arprot};

  // ---------------- Pin synchronisers ----------------
  logic ref_s1_q, ref_s2_q, ref_s3_q; // Index pin chain
  logic sck_s1_q, sck_s2_q, sck_s3_q; // Serial clock chain

  // Two stages before use; third stage only for edge finding
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {ref_s1_q, ref_s2_q, ref_s3_q} <= 3'h0;
      {sck_s1_q, sck_s2_q, sck_s3_q} <= 3'h7; // Serial clock idles high
    end else if (clk_en) begin
      {ref_s1_q, ref_s2_q, ref_s3_q} <= {ref_mark_pin, ref_s1_q, ref_s2_q};
      {sck_s1_q, sck_s2_q, sck_s3_q} <= {ssi_clk_pin, sck_s1_q, sck_s2_q};
    end
  end

  // 100 MHz sampling leaves ample margin at a 500 kHz link clock
  wire sck_rise = sck_s2_q & ~sck_s3_q;
  wire sck_fall = ~sck_s2_q & sck_s3_q;
  wire ref_rise = ref_s2_q & ~ref_s3_q;

  // ---------------- Register bus ----------------
  lqs_pkg::lqs_ctrl_t      ctrl_q;   // Option enables
  logic [lqs_pkg::IRQ_W-1:0] ist_q;  // Sticky events
  logic [lqs_pkg::IRQ_W-1:0] mask_q; // Event enables
  logic                    aw_have_q; // Write address held
  logic                    w_have_q;  // Write data held
  logic [7:0]              aw_addr_q;
  logic [31:0]             w_data_q;
  logic [3:0]              w_strb_q;
  logic                    bvalid_q;
  logic [1:0]              bresp_q;
  logic                    rvalid_q;
  logic [1:0]              rresp_q;
  logic [31:0]             rdata_q;

  // Bus stalls while clk_en is low so no handshake is lost
  assign s_axi_awready = clk_en & ~aw_have_q & ~bvalid_q;
  assign s_axi_wready  = clk_en & ~w_have_q & ~bvalid_q;
  assign s_axi_arready = clk_en & ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire ar_take  = s_axi_arvalid & s_axi_arready;
  wire do_write = aw_have_q & w_have_q & ~bvalid_q;

  // Write decode, byte enables widened to a bit mask
  wire [7:0]  wa     = {aw_addr_q[7:2], 2'h0};
  wire [31:0] wmask  = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                        {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [31:0] wbits  = w_data_q & wmask;
  wire wr_ctrl   = do_write & (wa == lqs_pkg::CTRL_OFS);
  wire wr_ist    = do_write & (wa == lqs_pkg::IRQ_ST_OFS);
  wire wr_mask   = do_write & (wa == lqs_pkg::IRQ_MASK_OFS);
  wire wr_preset = do_write & (wa == lqs_pkg::PRESET_OFS);
  wire wr_hit    = wr_ctrl | wr_ist | wr_mask | wr_preset;

  // Address and data may come in either order
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else if (clk_en) begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q  <= lqs_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? lqs_pkg::RESP_OKAY : lqs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Control register steers all three outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_q <= lqs_pkg::CTRL_RST;
      mask_q <= lqs_pkg::MASK_RST;
    end else if (clk_en) begin
      if (wr_ctrl) ctrl_q <= wbits[2:0];
      if (wr_mask) mask_q <= wbits[lqs_pkg::IRQ_W-1:0];
    end
  end

  // ---------------- Position and quadrature ----------------
  logic [lqs_pkg::POS_W-1:0] pos_q;   // Position, one count per 10 um
  logic [1:0]                phase_q; // Quadrature phase index
  logic                      err_q;   // Error flag, for edge finding

  // Preset wins over a step in the same cycle: software sets the written value
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pos_q   <= '0;
      phase_q <= 2'h0;
    end else if (clk_en) begin
      if (wr_preset) begin
        pos_q <= wbits[lqs_pkg::POS_W-1:0];
      end else if (step_pulse) begin
        pos_q <= step_up ? pos_q + 1'b1 : pos_q - 1'b1;
      end
      // One edge per step keeps the phase in step with position
      if (step_pulse) begin
        phase_q <= step_up ? phase_q + 2'h1 : phase_q - 2'h1;
      end
    end
  end

  // Phase 0..3 maps to AB 00,10,11,01: B trails A when counting up
  wire ch_a = phase_q[0] ^ phase_q[1];
  wire ch_b = phase_q[1];

  logic qa_q, qb_q, qz_q;    // Square-wave outputs
  logic [1:0] ap_q;          // Analog phase, AB
  logic az_q;                // Analog index

  // Analog stays live regardless of the serial link
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {qa_q, qb_q, qz_q} <= 3'h0;
      ap_q <= 2'h0;
      az_q <= 1'b0;
    end else if (clk_en) begin
      qa_q <= ctrl_q.square_wave_option & ch_a;
      qb_q <= ctrl_q.square_wave_option & ch_b;
      qz_q <= ctrl_q.square_wave_option & ref_s2_q;
      ap_q <= ctrl_q.analog_sine_option ? {ch_a, ch_b} : 2'h0;
      az_q <= ctrl_q.analog_sine_option & ref_s2_q;
    end
  end

  assign quad_a           = qa_q;
  assign quad_b           = qb_q;
  assign zero_index_pulse = qz_q;
  assign ana_phase        = ap_q;
  assign ana_index        = az_q;

  // ---------------- Serial absolute link ----------------
  lqs_pkg::lqs_frame_t frame;  // Live frame offered for latching
  logic ssi_busy;              // Transfer or hold in progress
  logic ssi_done;              // Frame completed strobe

  // One driver: position, even parity, error, warning
  assign frame = {pos_q, ^pos_q, err_in, warn_in};

  lqs_ssi_tx u_ssi (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .enable     (ctrl_q.serial_absolute_option),
    .sclk_rise  (sck_rise),
    .sclk_fall  (sck_fall),
    .frame      (frame),
    .data_out   (ssi_data),
    .busy       (ssi_busy),
    .frame_done (ssi_done)
  );

  // ---------------- Interrupts ----------------
  wire [lqs_pkg::IRQ_W-1:0] ev = {err_in & ~err_q, ref_rise, ssi_done};
  wire [lqs_pkg::IRQ_W-1:0] ist_clr =
    wr_ist ? wbits[lqs_pkg::IRQ_W-1:0] : '0;
  // A new event beats a clear in the same cycle
  wire [lqs_pkg::IRQ_W-1:0] ist_d = (ist_q & ~ist_clr) | ev;
  logic irq_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ist_q <= '0;
      err_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      ist_q <= ist_d;
      err_q <= err_in;
      irq_q <= |(ist_d & (wr_mask ? wbits[lqs_pkg::IRQ_W-1:0] : mask_q));
    end
  end
  assign irq = irq_q;

  // ---------------- Read path ----------------
  wire [7:0]  ra    = {s_axi_araddr[7:2], 2'h0};
  wire [31:0] flags = {28'h0, ssi_busy, ref_s2_q, warn_in, err_in};
  wire rd_hit = (ra == lqs_pkg::CTRL_OFS) | (ra == lqs_pkg::POS_OFS) |
                (ra == lqs_pkg::FLAG_OFS) | (ra == lqs_pkg::IRQ_ST_OFS) |
                (ra == lqs_pkg::IRQ_MASK_OFS) | (ra == lqs_pkg::PRESET_OFS);
  wire [31:0] rd_val =
    (ra == lqs_pkg::CTRL_OFS)     ? {29'h0, ctrl_q} :
    (ra == lqs_pkg::POS_OFS ||
     ra == lqs_pkg::PRESET_OFS)   ? {10'h0, pos_q} :
    (ra == lqs_pkg::FLAG_OFS)     ? flags :
    (ra == lqs_pkg::IRQ_ST_OFS)   ? {29'h0, ist_q} :
    (ra == lqs_pkg::IRQ_MASK_OFS) ? {29'h0, mask_q} : 32'h0000_0000;

  // Read data is captured at the address handshake
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rresp_q  <= lqs_pkg::RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (clk_en) begin
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rresp_q  <= rd_hit ? lqs_pkg::RESP_OKAY : lqs_pkg::RESP_SLVERR;
        rdata_q  <= rd_val;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ---------------- Checks ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_quad_one_edge: assert property (
    clk_en && step_pulse && !wr_ctrl && ctrl_q.square_wave_option
    ##1 clk_en |=> $countones({quad_a ^ $past(quad_a),
                               quad_b ^ $past(quad_b)}) == 1)
    else $error("square-wave step did not move exactly one edge");
  a_b_lags_a: assert property (
    clk_en && step_pulse && step_up && phase_q == 2'h0
    |=> ch_a && !ch_b)
    else $error("A did not lead B on positive motion");
  a_index_idle_low: assert property (
    clk_en && !ref_s2_q |=> !zero_index_pulse && !ana_index)
    else $error("index high away from reference mark");
  a_pos_step_up: assert property (
    clk_en && step_pulse && step_up && !wr_preset
    |=> pos_q == $past(pos_q) + 1'b1)
    else $error("position did not advance by one step");
  a_analog_live: assert property (
    clk_en && step_pulse && ssi_busy && ctrl_q.analog_sine_option
    && !wr_ctrl ##1 clk_en |=> ana_phase != $past(ana_phase))
    else $error("analog phase stalled during serial transfer");
  a_frame_parity: assert property (
    ^{frame.pos, frame.parity} == 1'b0)
    else $error("frame parity is not even");
  a_irq_event: assert property (
    clk_en && ssi_done && mask_q[lqs_pkg::IRQ_FRAME] && !wr_mask
    |=> irq ##0 ist_q[lqs_pkg::IRQ_FRAME])
    else $error("frame event did not raise interrupt");
  a_set_beats_clr: assert property (
    clk_en && ref_rise |=> ist_q[lqs_pkg::IRQ_REF])
    else $error("reference event lost");

  a_freeze_state: assert property (
    !clk_en |=> $stable(pos_q) && $stable(phase_q) && $stable(ist_q))
    else $error("state moved while clock enable low");

  c_step_up:   cover property (clk_en && step_pulse && step_up);
  c_step_down: cover property (clk_en && step_pulse && !step_up);
  c_ref_mark:  cover property (ref_rise);
  c_irq:       cover property ($rose(irq));
endmodule

// *** verif/lqs_ssi_eval.sv ***
// Evaluation unit model: drives the serial clock, collects one frame.
// Assumes data_in is the block's serial data output, sampled on falls.
`timescale 1ns/1ps
module lqs_ssi_eval #(
  parameter int HALF_CYC = 8 // Half period in ref_clk cycles, 160 ns clock
) (
  input  wire logic ref_clk,
  input  wire logic data_in,
  output logic      sclk
);
  // Clock stands high between frames
  initial sclk = 1'b1;

  // First fall latches, falls 1..25 sample MSB first, 26th rise ends
  task automatic read_frame(output logic [24:0] f, output logic par_ok);
    f = '0;
    for (int i = 0; i < 26; i++) begin
      @(posedge ref_clk);
      if (i > 0) f = {f[23:0], data_in};
      sclk <= 1'b0;
      // Faster than a field link may run, to keep the run short
      repeat (HALF_CYC) @(posedge ref_clk);
      sclk <= 1'b1;
      repeat (HALF_CYC - 1) @(posedge ref_clk);
    end
    // Even ones over position plus parity
    par_ok = ~^f[24:2];
  endtask
endmodule

// *** verif/lqs_top_tb_top.sv ***
// Self-checking bench for the encoder output block.
// Assumes lqs_pkg, lqs_top and the evaluation model compile first.
`timescale 1ns/1ps
module lqs_top_tb_top;
  logic        ref_clk = 0, rst_n = 0, clk_en = 1, ref_pin = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, sclk;
  logic [1:0]  bresp, rresp, ana_phase;
  logic        step_pulse = 0, step_up = 0, err_in = 0, warn_in = 0;
  logic        quad_a, quad_b, zero_idx, ana_index, ssi_data, irq;
  logic [2:0]  ctrl_m = 3'h7; // Expected option enables
  logic [21:0] pos = 0;       // Expected position
  int          fails = 0, n_checks = 0, cyc = 0, ph = 0;
  int          q_cnt = 0, q_exp = 0; // Decoded and expected edge count
  logic [1:0]  q_prev = 0;           // Last seen {A,B}

  lqs_top i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .step_pulse(step_pulse), .step_up(step_up),
    .err_in(err_in), .warn_in(warn_in), .ref_mark_pin(ref_pin),
    .ssi_clk_pin(sclk), .quad_a(quad_a), .quad_b(quad_b),
    .zero_index_pulse(zero_idx), .ana_phase(ana_phase),
    .ana_index(ana_index), .ssi_data(ssi_data), .irq(irq));

  lqs_ssi_eval i_ssi (.ref_clk(ref_clk), .data_in(ssi_data), .sclk(sclk));

  // Evaluation side up/down count, one count per single-bit edge
  always @(negedge ref_clk) begin
    q_prev <= {quad_a, quad_b};
    if (rst_n && ^({quad_a, quad_b} ^ q_prev)) begin
      q_cnt <= (q_prev[1] == quad_b) ? q_cnt + 1 : q_cnt - 1;
    end
  end

  // 100 MHz clock and hang guard
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  // Phase picture {A,B}, B lagging A when counting up
  function automatic logic [1:0] ab(int p);
    return (p == 0) ? 2'h0 : (p == 1) ? 2'h2 : (p == 2) ? 2'h3 : 2'h1;
  endfunction

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One bus transfer; readies looked at mid-cycle, taken at next edge
  task automatic bus(bit w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    bit ga, gw, gr, done;
    int n;
    @(posedge ref_clk);
    if (w) begin
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    end else begin
      araddr <= a; arvalid <= 1; rready <= 1;
    end
    done = 0;
    for (n = 0; n < 100 && !done; n++) begin
      @(negedge ref_clk);
      ga = awvalid & awready;
      gw = wvalid & wready;
      gr = arvalid & arready;
      done = w ? bvalid : (rvalid & !arvalid);
      q = rdata;
      r = w ? bresp : rresp;
      @(posedge ref_clk);
      if (ga) awvalid <= 0;
      if (gw) wvalid <= 0;
      if (gr) arvalid <= 0;
    end
    bready <= 0;
    rready <= 0;
    if (!done) chk("bus answer", 0, 1);
  endtask

  task automatic rd(string nm, logic [7:0] a, logic [31:0] e, logic [1:0] er);
    logic [31:0] q;
    logic [1:0]  r;
    bus(0, a, 0, q, r);
    chk(nm, q, e);
    chk("rresp", 32'(r), 32'(er));
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    logic [31:0] q;
    logic [1:0]  r;
    bus(1, a, d, q, r);
    chk("bresp", 32'(r), 32'(er));
  endtask

  // One travel step, outputs settle one edge after it is taken
  task automatic do_step(logic up);
    @(posedge ref_clk);
    step_pulse <= 1;
    step_up <= up;
    @(posedge ref_clk);
    step_pulse <= 0;
    pos = up ? pos + 22'h1 : pos - 22'h1;
    ph = up ? (ph + 1) % 4 : (ph + 3) % 4;
    q_exp = up ? q_exp + 1 : q_exp - 1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("quad", 32'({quad_a, quad_b}), ctrl_m[0] ? 32'(ab(ph)) : 0);
    chk("ana", 32'(ana_phase), ctrl_m[1] ? 32'(ab(ph)) : 0);
  endtask

  initial begin
    logic [24:0] f, e;
    logic [21:0] p;
    logic        pok, wv;
    void'($urandom(4));
    repeat (20) @(posedge ref_clk);
    rst_n <= 1;
    // Reset values and an unmapped place
    rd("ctrl", lqs_pkg::CTRL_OFS, 32'h7, lqs_pkg::RESP_OKAY);
    rd("mask", lqs_pkg::IRQ_MASK_OFS, 0, lqs_pkg::RESP_OKAY);
    rd("hole", 8'h18, 0, lqs_pkg::RESP_SLVERR);
    wr(8'h18, 32'hffffffff, lqs_pkg::RESP_SLVERR);
    // Random walk, 40 single steps one at a time
    for (int i = 0; i < 40; i++) do_step(1'($urandom));
    rd("pos", lqs_pkg::POS_OFS, 32'(pos), lqs_pkg::RESP_OKAY);
    // Enable low freezes all state, a step included
    clk_en <= 0;
    @(posedge ref_clk);
    step_pulse <= 1;
    @(posedge ref_clk);
    step_pulse <= 0;
    clk_en <= 1;
    rd("frozen pos", lqs_pkg::POS_OFS, 32'(pos), lqs_pkg::RESP_OKAY);
    // Reference mark, interrupt raise, mask, clear
    wr(lqs_pkg::IRQ_MASK_OFS, 32'h7, lqs_pkg::RESP_OKAY);
    ref_pin <= 1;
    repeat (6) @(negedge ref_clk);
    chk("index", 32'({zero_idx, ana_index}), 32'h3);
    chk("irq", 32'(irq), 1);
    wr(lqs_pkg::IRQ_MASK_OFS, 0, lqs_pkg::RESP_OKAY);
    @(negedge ref_clk);
    chk("irq", 32'(irq), 0);
    rd("status", lqs_pkg::IRQ_ST_OFS, 32'h2, lqs_pkg::RESP_OKAY);
    wr(lqs_pkg::IRQ_ST_OFS, 32'h2, lqs_pkg::RESP_OKAY);
    ref_pin <= 0;
    repeat (6) @(negedge ref_clk);
    chk("index", 32'({zero_idx, ana_index}), 0);
    rd("status", lqs_pkg::IRQ_ST_OFS, 0, lqs_pkg::RESP_OKAY);
    // Mark rise lands in the cycle of its clear: the event wins
    ref_pin <= 1;
    wr(lqs_pkg::IRQ_ST_OFS, 32'h2, lqs_pkg::RESP_OKAY);
    rd("status", lqs_pkg::IRQ_ST_OFS, 32'h2, lqs_pkg::RESP_OKAY);
    ref_pin <= 0;
    wr(lqs_pkg::IRQ_ST_OFS, 32'h2, lqs_pkg::RESP_OKAY);
    wr(lqs_pkg::IRQ_MASK_OFS, 32'h1, lqs_pkg::RESP_OKAY);
    // Frames, all-ones corner first, a step while one is under way
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 22'h3fffff : 22'($urandom);
      wv = 1'($urandom);
      wr(lqs_pkg::PRESET_OFS, 32'(p), lqs_pkg::RESP_OKAY);
      pos = p;
      err_in <= i[0];
      warn_in <= wv;
      e = {p, ^p, i[0], wv};
      fork
        i_ssi.read_frame(f, pok);
        begin
          repeat (60) @(posedge ref_clk);
          do_step(1);
          rd("flags", lqs_pkg::FLAG_OFS, 32'({2'h2, wv, i[0]}),
             lqs_pkg::RESP_OKAY);
        end
      join
      chk("frame", 32'(f), 32'(e));
      chk("parity ok", 32'(pok), 1);
      chk("irq", 32'(irq), 1);
      rd("status", lqs_pkg::IRQ_ST_OFS, (i == 1) ? 32'h5 : 32'h1,
         lqs_pkg::RESP_OKAY);
      wr(lqs_pkg::IRQ_ST_OFS, 32'h7, lqs_pkg::RESP_OKAY);
      @(negedge ref_clk);
      chk("irq", 32'(irq), 0);
      chk("ssi hold", 32'(ssi_data), 0);
      repeat (2000) @(negedge ref_clk);
      chk("ssi idle", 32'(ssi_data), 1);
    end
    chk("quad count", 32'(q_cnt), 32'(q_exp));
    // All options off, then back on
    wr(lqs_pkg::CTRL_OFS, 0, lqs_pkg::RESP_OKAY);
    ctrl_m = 0;
    do_step(0);
    i_ssi.read_frame(f, pok);
    chk("no frame", 32'(f), 32'h1ffffff);
    wr(lqs_pkg::CTRL_OFS, 32'h7, lqs_pkg::RESP_OKAY);
    ctrl_m = 3'h7;
    do_step(1);
    wrap_up();
  end
endmodule
